// ===== hdl/fct_pkg.sv
// constants for the fpu context trap unit: control bits, vectors, image sizes
// assumes one processor clock domain and an instruction issue stage upstream
package fct_pkg;
   // control register layout
   localparam int          CR_W       = 32;
   localparam int          CR_EM_BIT  = 2;
   localparam int          CR_TS_BIT  = 3;
   localparam int          CR_NE_BIT  = 5;
   localparam logic [31:0] CR_RST     = 32'h0000_0000;
   // pending numeric exception flags
   localparam int          FLAG_W     = 6;
   localparam logic [5:0]  FLAG_RST   = 6'h00;
   // exception vectors
   localparam logic [7:0]  VEC_NONE   = 8'h00;
   localparam logic [7:0]  VEC_UD     = 8'h06;
   localparam logic [7:0]  VEC_DNA    = 8'h07;
   localparam logic [7:0]  VEC_GP     = 8'h0d;
   localparam logic [7:0]  VEC_MF     = 8'h10;
   // save image sizes in bytes
   localparam logic [9:0]  IMG_LEG16  = 10'h05e;
   localparam logic [9:0]  IMG_LEG32  = 10'h06c;
   localparam logic [9:0]  IMG_EXT    = 10'h200;
   localparam logic [9:0]  IMG_NONE   = 10'h000;
   // extended image alignment: low address bits that must be zero
   localparam int          EXT_ALIGN_BITS = 4;
   // image layout selector
   localparam logic        FMT_LEGACY = 1'b0;
   localparam logic        FMT_EXT    = 1'b1;
   // instruction classes offered to the unit
   typedef enum logic [3:0] {
      OP_OTHER      = 4'h0,
      OP_FP         = 4'h1,
      OP_WAIT       = 4'h2,
      OP_PACKED_INT = 4'h3,
      OP_LEG_SAVE   = 4'h4,
      OP_LEG_SAVE_NW= 4'h5,
      OP_LEG_REST   = 4'h6,
      OP_EXT_SAVE   = 4'h7,
      OP_EXT_REST   = 4'h8,
      OP_CLR_TS     = 4'h9
   } fct_op_t;
endpackage

// ===== hdl/fct_trap_unit.sv
// fpu context trap unit: lazy context trap, numeric error signalling, save/restore checks
// assumes one issue per cycle from an issue stage on clk_in; flag inputs are same-clock
// Function
// RL1: emulation flag also raises device-not-available trap
// RL2: emulation flag makes packed-integer ops invalid opcode
// RL3: task-switched flag faults fp op before execution
// RL4: device-not-available beats pending numeric exception
// RL5: no-wait legacy save with pending asserts error output
// RL6: numeric exception may arrive any time before next
// RL7: native reporting off: software tolerates interrupt timing
// RL8: restore reloads saved pending flags into status
// RL9: restored pending flags fault resumed fp op
// RL10: faulted fp op re-executes from its start
// RL11: clear-task-switched op clears task-switched flag
// RL12: legacy image 94 bytes 16-bit, 108 bytes 32-bit
// RL13: extended image is 512 bytes
// RL14: extended image must be 16-byte aligned
// RL15: extended image uses its own layout
// RL16: legacy save reinitialises, extended save leaves state
// RL17: native reporting delivers numeric exception via vector 16
// RL18: task-switched is bit 3, set on task switch
// RL19: device-not-available trap uses vector 7
`timescale 1ns/100ps
module fct_trap_unit #(
   parameter int ADDR_W = 32                  // operand address width
) (
   input  wire logic              clk_in,             // processor clock, 250 MHz
   input  wire logic              rstn_in,            // async reset, active low
   input  wire logic              issue_valid_in,     // instruction offered this cycle
   input  wire fct_pkg::fct_op_t  issue_op_in,        // class of offered instruction
   input  wire logic              issue_op32_in,      // 32-bit operand mode
   input  wire logic [ADDR_W-1:0] issue_addr_in,      // save/restore image address
   output logic                   issue_ready_out,    // unit takes an offer
   input  wire logic              cr_wr_in,           // control register write strobe
   input  wire logic [31:0]       cr_wdata_in,        // control register write data
   input  wire logic              task_switch_in,     // hardware task switch pulse
   input  wire logic              fp_exc_in,          // unmasked numeric exception pulse
   input  wire logic [5:0]        fp_exc_flags_in,    // flags of that exception
   input  wire logic [5:0]        restore_flags_in,   // pending flags read from image
   output logic                   done_valid_out,     // outcome of previous offer
   output logic                   done_fault_out,     // offer faulted, not executed
   output logic                   done_retry_out,     // faulted op re-runs from start
   output logic [7:0]             done_vector_out,    // vector of the fault
   output logic [9:0]             img_bytes_out,      // bytes moved by save/restore
   output logic                   img_format_out,     // image layout, legacy or extended
   output logic                   fpu_init_out,       // reinitialise fpu pulse
   output logic [31:0]            machine_control_reg_out, // control register value
   output logic [5:0]             status_flags_out,   // pending flags in status word
   output logic                   fp_error_out_n      // error output, active low
);

   // parameter check
   if (ADDR_W < fct_pkg::EXT_ALIGN_BITS + 1) begin : g_addr_w_check
      $error("ADDR_W too small for alignment check");
   end

   // reset release through two flops
   logic rst_meta_ff;
   logic rst_sync_ff;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   wire rstn = rst_sync_ff;

   // class decode used by the fault logic and the checks
   function automatic logic uses_fpu(input fct_pkg::fct_op_t op);
      case (op)
         fct_pkg::OP_FP, fct_pkg::OP_WAIT, fct_pkg::OP_LEG_SAVE,
         fct_pkg::OP_LEG_SAVE_NW, fct_pkg::OP_LEG_REST,
         fct_pkg::OP_EXT_SAVE, fct_pkg::OP_EXT_REST: uses_fpu = 1'b1;
         default:                                   uses_fpu = 1'b0;
      endcase
   endfunction

   // waiting ops take a pending numeric exception first; no-wait save does not
   function automatic logic checks_pending(input fct_pkg::fct_op_t op);
      case (op)
         fct_pkg::OP_FP, fct_pkg::OP_WAIT, fct_pkg::OP_LEG_SAVE,
         fct_pkg::OP_LEG_REST, fct_pkg::OP_EXT_SAVE,
         fct_pkg::OP_EXT_REST: checks_pending = 1'b1;
         default:              checks_pending = 1'b0;
      endcase
   endfunction

   // control state
   logic       em_ff;
   logic       ts_ff;
   logic       ne_ff;
   logic [5:0] pend_ff;

   // the unit never stalls once out of reset
   assign issue_ready_out = rstn;
   wire take = issue_valid_in && rstn;

   // fault resolution, ordered by priority
   logic       nxt_fault;
   logic [7:0] nxt_vec;
   logic       misaligned;
   always_comb begin
      misaligned = (issue_addr_in[fct_pkg::EXT_ALIGN_BITS-1:0] != '0);
      nxt_fault  = 1'b0;
      nxt_vec    = fct_pkg::VEC_NONE;
      if (issue_op_in == fct_pkg::OP_PACKED_INT && em_ff) begin
         nxt_fault = 1'b1;                                      // RL2
         nxt_vec   = fct_pkg::VEC_UD;
      end else if ((uses_fpu(issue_op_in) && (ts_ff || em_ff)) ||
                   (issue_op_in == fct_pkg::OP_PACKED_INT && ts_ff)) begin
         nxt_fault = 1'b1;                                      // RL1 RL3 RL4
         nxt_vec   = fct_pkg::VEC_DNA;                          // RL19
      end else if (checks_pending(issue_op_in) && ne_ff && (pend_ff != '0)) begin
         nxt_fault = 1'b1;                                      // RL9 RL17
         nxt_vec   = fct_pkg::VEC_MF;
      end else if ((issue_op_in == fct_pkg::OP_EXT_SAVE ||
                    issue_op_in == fct_pkg::OP_EXT_REST) && misaligned) begin
         nxt_fault = 1'b1;                                      // RL14
         nxt_vec   = fct_pkg::VEC_GP;
      end
   end

   // an offer executes only when it does not fault
   wire exec = take && !nxt_fault;
   wire do_clear_task_switched_op   = exec && (issue_op_in == fct_pkg::OP_CLR_TS);
   wire do_lsave  = exec && (issue_op_in == fct_pkg::OP_LEG_SAVE ||
                             issue_op_in == fct_pkg::OP_LEG_SAVE_NW);
   wire do_lrest  = exec && (issue_op_in == fct_pkg::OP_LEG_REST);
   wire do_xrest  = exec && (issue_op_in == fct_pkg::OP_EXT_REST);
   wire nw_save_pend = exec && (issue_op_in == fct_pkg::OP_LEG_SAVE_NW) && (pend_ff != '0);

   // control bits; a task switch wins over a clear in the same cycle
   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) begin
         em_ff <= fct_pkg::CR_RST[fct_pkg::CR_EM_BIT];
         ne_ff <= fct_pkg::CR_RST[fct_pkg::CR_NE_BIT];
         ts_ff <= fct_pkg::CR_RST[fct_pkg::CR_TS_BIT];
      end else begin
         if (cr_wr_in) begin
            em_ff <= cr_wdata_in[fct_pkg::CR_EM_BIT];
            ne_ff <= cr_wdata_in[fct_pkg::CR_NE_BIT];
         end
         if (task_switch_in)
            ts_ff <= 1'b1;                                      // RL18
         else if (do_clear_task_switched_op)
            ts_ff <= 1'b0;                                      // RL11
         else if (cr_wr_in)
            ts_ff <= cr_wdata_in[fct_pkg::CR_TS_BIT];
      end
   end

   // pending flags: a new exception wins over clear or reload
   logic [5:0] nxt_pend;
   always_comb begin
      nxt_pend = pend_ff;
      if (do_lrest || do_xrest)
         nxt_pend = restore_flags_in;                           // RL8
      else if (do_lsave)
         nxt_pend = fct_pkg::FLAG_RST;                          // RL16
      if (fp_exc_in)
         nxt_pend = nxt_pend | fp_exc_flags_in;                 // RL6
   end

   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn)
         pend_ff <= fct_pkg::FLAG_RST;
      else
         pend_ff <= nxt_pend;
   end

   // error output follows pending flags, held a cycle past a no-wait save
   logic fp_error_out_n_n_ff;
   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn)
         fp_error_out_n_n_ff <= 1'b1;
      else
         fp_error_out_n_n_ff <= !((nxt_pend != '0) || nw_save_pend);      // RL5 RL7
   end

   // outcome of each offer, one cycle after it is taken
   logic       dvalid_ff;
   logic       dfault_ff;
   logic [7:0] dvec_ff;
   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) begin
         dvalid_ff <= 1'b0;
         dfault_ff <= 1'b0;
         dvec_ff   <= fct_pkg::VEC_NONE;
      end else begin
         dvalid_ff <= take;
         dfault_ff <= take && nxt_fault;                        // RL10
         dvec_ff   <= take ? nxt_vec : fct_pkg::VEC_NONE;
      end
   end

   // image size and layout of an executed save or restore
   logic [9:0] img_ff;
   logic       fmt_ff;
   logic       init_ff;
   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) begin
         img_ff  <= fct_pkg::IMG_NONE;
         fmt_ff  <= fct_pkg::FMT_LEGACY;
         init_ff <= 1'b0;
      end else begin
         init_ff <= do_lsave;                                   // RL16
         if (do_lsave || do_lrest) begin
            img_ff <= issue_op32_in ? fct_pkg::IMG_LEG32 : fct_pkg::IMG_LEG16; // RL12
            fmt_ff <= fct_pkg::FMT_LEGACY;
         end else if (exec && (issue_op_in == fct_pkg::OP_EXT_SAVE || do_xrest)) begin
            img_ff <= fct_pkg::IMG_EXT;                         // RL13
            fmt_ff <= fct_pkg::FMT_EXT;                         // RL15
         end else begin
            img_ff <= fct_pkg::IMG_NONE;
         end
      end
   end

   // outputs
   assign done_valid_out   = dvalid_ff;
   assign done_fault_out   = dfault_ff;
   assign done_retry_out   = dfault_ff;
   assign done_vector_out  = dvec_ff;
   assign img_bytes_out    = img_ff;
   assign img_format_out   = fmt_ff;
   assign fpu_init_out     = init_ff;
   assign status_flags_out = pend_ff;
   assign fp_error_out_n   = fp_error_out_n_n_ff;
   always_comb begin
      machine_control_reg_out = fct_pkg::CR_RST;
      machine_control_reg_out[fct_pkg::CR_EM_BIT] = em_ff;
      machine_control_reg_out[fct_pkg::CR_TS_BIT] = ts_ff;
      machine_control_reg_out[fct_pkg::CR_NE_BIT] = ne_ff;
   end

   // checks
   sequence s_fp_offer_ts;
      issue_valid_in && rstn && ts_ff && uses_fpu(issue_op_in);
   endsequence
   sequence s_dna_out;
      done_valid_out && done_fault_out && done_vector_out == fct_pkg::VEC_DNA;
   endsequence

   property p_ts_dna;
      @(posedge clk_in) disable iff (!rstn) s_fp_offer_ts |=> s_dna_out;
   endproperty
   a_ts_dna: assert property (p_ts_dna) else $error("ts fp op not trapped"); // RL3

   property p_em_dna;
      @(posedge clk_in) disable iff (!rstn)
         issue_valid_in && em_ff && uses_fpu(issue_op_in) |=> s_dna_out;
   endproperty
   a_em_dna: assert property (p_em_dna) else $error("em fp op not trapped"); // RL1

   property p_em_ud;
      @(posedge clk_in) disable iff (!rstn)
         issue_valid_in && em_ff && issue_op_in == fct_pkg::OP_PACKED_INT
         |=> done_fault_out && done_vector_out == fct_pkg::VEC_UD;
   endproperty
   a_em_ud: assert property (p_em_ud) else $error("packed op not refused"); // RL2

   property p_dna_first;
      @(posedge clk_in) disable iff (!rstn)
         s_fp_offer_ts and (issue_valid_in && ne_ff && pend_ff != '0)
         |=> done_vector_out != fct_pkg::VEC_MF;
   endproperty
   a_dna_first: assert property (p_dna_first) else $error("numeric beat dna"); // RL4

   property p_mf_vec;
      @(posedge clk_in) disable iff (!rstn)
         issue_valid_in && !ts_ff && !em_ff && ne_ff && pend_ff != '0 &&
         issue_op_in == fct_pkg::OP_FP |=> done_vector_out == fct_pkg::VEC_MF;
   endproperty
   a_mf_vec: assert property (p_mf_vec) else $error("no vector 16"); // RL17

   property p_nw_fp_error_out_n;
      @(posedge clk_in) disable iff (!rstn)
         nw_save_pend |=> !fp_error_out_n;
   endproperty
   a_nw_fp_error_out_n: assert property (p_nw_fp_error_out_n) else $error("error output not asserted"); // RL5

   property p_clear_task_switched_op;
      @(posedge clk_in) disable iff (!rstn)
         do_clear_task_switched_op && !task_switch_in |=> !ts_ff;
   endproperty
   a_clear_task_switched_op: assert property (p_clear_task_switched_op) else $error("ts not cleared"); // RL11

   property p_tsw;
      @(posedge clk_in) disable iff (!rstn)
         task_switch_in |=> ts_ff && machine_control_reg_out[fct_pkg::CR_TS_BIT];
   endproperty
   a_tsw: assert property (p_tsw) else $error("task switch did not set ts"); // RL18

   property p_restore;
      @(posedge clk_in) disable iff (!rstn)
         do_lrest && !fp_exc_in |=> status_flags_out == $past(restore_flags_in);
   endproperty
   a_restore: assert property (p_restore) else $error("flags not reloaded"); // RL8

   property p_leg_size;
      @(posedge clk_in) disable iff (!rstn)
         do_lsave |=> fpu_init_out && img_bytes_out ==
            ($past(issue_op32_in) ? fct_pkg::IMG_LEG32 : fct_pkg::IMG_LEG16);
   endproperty
   a_leg_size: assert property (p_leg_size) else $error("legacy save wrong"); // RL12

   property p_ext_save;
      @(posedge clk_in) disable iff (!rstn)
         exec && issue_op_in == fct_pkg::OP_EXT_SAVE && !fp_exc_in
         |=> !fpu_init_out && img_bytes_out == fct_pkg::IMG_EXT &&
             img_format_out == fct_pkg::FMT_EXT && $stable(status_flags_out);
   endproperty
   a_ext_save: assert property (p_ext_save) else $error("extended save wrong"); // RL13

   property p_align;
      @(posedge clk_in) disable iff (!rstn)
         issue_valid_in && !ts_ff && !em_ff && !(ne_ff && pend_ff != '0) &&
         issue_op_in == fct_pkg::OP_EXT_SAVE && misaligned
         |=> done_fault_out && done_vector_out == fct_pkg::VEC_GP && img_bytes_out == '0;
   endproperty
   a_align: assert property (p_align) else $error("misaligned image taken"); // RL14

endmodule

// ===== dv/fct_os_model.sv
// kernel model: device-not-available handler that takes over the issue port
// assumes the bench passes these outputs to the unit while busy_out is high
`timescale 1ns/100ps
module fct_os_model (
   input  wire logic        clk_in,     // processor clock
   input  wire logic        en_in,      // handler armed
   input  wire logic        trap_in,    // dna trap reported
   input  wire logic [5:0]  flags_in,   // pending flags of the unit
   output logic             busy_out,   // handler owns the issue port
   output fct_pkg::fct_op_t op_out,     // handler instruction
   output logic [31:0]      addr_out,   // save area address
   output logic [5:0]       rflags_out  // pending flags from the image
);
   logic [2:0] step_ff = 3'h0;
   logic [5:0] saved_ff = 6'h00;
   // steps: clear ts, no-wait save, restore, retry the faulted op
   always_ff @(posedge clk_in) begin
      if (step_ff == 3'h4) step_ff <= 3'h0;
      else if (step_ff != 3'h0 || (en_in && trap_in)) step_ff <= step_ff + 3'h1;
      if (step_ff == 3'h2) saved_ff <= flags_in;
   end
   assign busy_out = step_ff != 3'h0;
   assign addr_out = 32'h0000_2000;
   // image flags only meaningful on the restore step
   assign rflags_out = (step_ff == 3'h3) ? saved_ff : ~saved_ff;
   // handler op table
   always_comb begin
      case (step_ff)
         3'h1: op_out = fct_pkg::OP_CLR_TS;
         3'h2: op_out = fct_pkg::OP_LEG_SAVE_NW;
         3'h3: op_out = fct_pkg::OP_LEG_REST;
         default: op_out = fct_pkg::OP_FP;
      endcase
   end
endmodule

// ===== dv/tb_top.sv
// bench for the fpu context trap unit: corner and random instruction streams
// assumes the unit answers one cycle after each offer, partner model alongside
`timescale 1ns/100ps
module tb_top;
   logic             clk_in = 1'b0;
   logic             rstn_in = 1'b0;
   logic             issue_valid_in, issue_op32_in, cr_wr_in, task_switch_in, fp_exc_in;
   fct_pkg::fct_op_t issue_op_in, os_op;
   logic [31:0]      issue_addr_in, cr_wdata_in, machine_control_reg_out, os_addr, r;
   logic [5:0]       fp_exc_flags_in, restore_flags_in, status_flags_out, os_rflags, fl_s;
   logic             issue_ready_out, done_valid_out, done_fault_out, done_retry_out;
   logic             img_format_out, fpu_init_out, fp_error_out_n, os_busy, os_en = 1'b0;
   logic             em_s, ts_s, ne_s, e_on = 1'b0, e_val, e_flt, e_init, e_fp_error_out_n, e_fchk, e_fmt;
   logic [7:0]       done_vector_out, e_vec;
   logic [9:0]       img_bytes_out, e_bytes;
   int               n_mismatch = 0, comparisons = 0, seed = 32'h4dbd1336;
   // 250 MHz clock
   always #2 clk_in = ~clk_in;
   fct_trap_unit dut (.clk_in(clk_in), .rstn_in(rstn_in), .issue_valid_in(issue_valid_in),
      .issue_op_in(issue_op_in), .issue_op32_in(issue_op32_in), .issue_addr_in(issue_addr_in),
      .issue_ready_out(issue_ready_out), .cr_wr_in(cr_wr_in), .cr_wdata_in(cr_wdata_in),
      .task_switch_in(task_switch_in), .fp_exc_in(fp_exc_in), .fp_exc_flags_in(fp_exc_flags_in),
      .restore_flags_in(restore_flags_in), .done_valid_out(done_valid_out),
      .done_fault_out(done_fault_out), .done_retry_out(done_retry_out),
      .done_vector_out(done_vector_out), .img_bytes_out(img_bytes_out),
      .img_format_out(img_format_out), .fpu_init_out(fpu_init_out),
      .machine_control_reg_out(machine_control_reg_out), .status_flags_out(status_flags_out),
      .fp_error_out_n(fp_error_out_n));
   fct_os_model os (.clk_in(clk_in), .en_in(os_en & ~machine_control_reg_out[2]),
      .trap_in(done_valid_out & done_fault_out & (done_vector_out == fct_pkg::VEC_DNA)),
      .flags_in(status_flags_out), .busy_out(os_busy), .op_out(os_op), .addr_out(os_addr),
      .rflags_out(os_rflags));
   // compare and count
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // expected fault vector for an offer in the present state
   function automatic logic [7:0] vec_of(fct_pkg::fct_op_t op, logic [3:0] lo);
      if (op == fct_pkg::OP_PACKED_INT && em_s) return fct_pkg::VEC_UD;
      if ((op == fct_pkg::OP_FP || op == fct_pkg::OP_PACKED_INT) && (ts_s || em_s))
         return fct_pkg::VEC_DNA;
      if ((op == fct_pkg::OP_FP || op == fct_pkg::OP_WAIT) && ne_s && fl_s != 6'h00)
         return fct_pkg::VEC_MF;
      if ((op == fct_pkg::OP_EXT_SAVE || op == fct_pkg::OP_EXT_REST) && lo != 4'h0)
         return fct_pkg::VEC_GP;
      return fct_pkg::VEC_NONE;
   endfunction
   // offers whose outcome is left open are swapped for a plain op
   function automatic logic legal(fct_pkg::fct_op_t op);
      case (op)
         fct_pkg::OP_OTHER, fct_pkg::OP_CLR_TS, fct_pkg::OP_FP: return 1'b1;
         fct_pkg::OP_PACKED_INT: return ts_s || em_s || !ne_s || fl_s == 6'h00;
         fct_pkg::OP_WAIT, fct_pkg::OP_LEG_SAVE_NW: return !(ts_s || em_s);
         default: return !(ts_s || em_s) && !(ne_s && fl_s != 6'h00);
      endcase
   endfunction
   // expected image size of an executed op
   function automatic logic [9:0] img_of(fct_pkg::fct_op_t op, logic o32);
      case (op)
         fct_pkg::OP_LEG_SAVE, fct_pkg::OP_LEG_SAVE_NW, fct_pkg::OP_LEG_REST:
            return o32 ? fct_pkg::IMG_LEG32 : fct_pkg::IMG_LEG16;
         fct_pkg::OP_EXT_SAVE, fct_pkg::OP_EXT_REST: return fct_pkg::IMG_EXT;
         default: return fct_pkg::IMG_NONE;
      endcase
   endfunction
   // one cycle: check last edge, drive next inputs, predict their outcome
   task automatic drv(logic v, fct_pkg::fct_op_t op, logic o32, logic [31:0] a, logic cw,
                      logic [31:0] cd, logic tsw, logic ex, logic [5:0] ef, logic [5:0] rf);
      logic [7:0] vec;
      logic       run, lsv, rst;
      logic [5:0] base;
      @(negedge clk_in);
      if (e_on) begin
         chk("valid", done_valid_out, e_val);
         chk("fault", done_fault_out, e_flt);
         chk("retry", done_retry_out, e_flt);
         chk("vector", done_vector_out, e_vec);
         chk("bytes", img_bytes_out, e_bytes);
         if (e_fchk) chk("format", img_format_out, e_fmt);
         chk("init", fpu_init_out, e_init);
         chk("ctrl", machine_control_reg_out, {26'h0, ne_s, 1'b0, ts_s, em_s, 2'h0});
         chk("flags", status_flags_out, fl_s);
         chk("err_n", fp_error_out_n, e_fp_error_out_n);
      end
      if (os_busy) begin
         {v, a, rf} = {1'b1, os_addr, os_rflags};
         op = os_op;
         {cw, tsw, ex} = 3'h0;
      end
      if (!legal(op)) op = fct_pkg::OP_OTHER;
      if (v && op inside {[fct_pkg::OP_LEG_SAVE:fct_pkg::OP_EXT_REST]}) ex = 1'b0;
      {issue_valid_in, issue_op32_in, issue_addr_in} = {v, o32, a};
      issue_op_in = op;
      {cr_wr_in, cr_wdata_in, task_switch_in} = {cw, cd, tsw};
      {fp_exc_in, fp_exc_flags_in, restore_flags_in} = {ex, ef, rf};
      vec = v ? vec_of(op, a[3:0]) : fct_pkg::VEC_NONE;
      run = v && vec == fct_pkg::VEC_NONE;
      lsv = run && (op == fct_pkg::OP_LEG_SAVE || op == fct_pkg::OP_LEG_SAVE_NW);
      rst = run && (op == fct_pkg::OP_LEG_REST || op == fct_pkg::OP_EXT_REST);
      {e_on, e_val, e_flt, e_vec, e_init} = {1'b1, v, v && !run, vec, lsv};
      e_bytes = run ? img_of(op, o32) : fct_pkg::IMG_NONE;
      e_fchk = e_bytes != fct_pkg::IMG_NONE;
      e_fmt = op == fct_pkg::OP_EXT_SAVE || op == fct_pkg::OP_EXT_REST;
      base = (lsv ? 6'h00 : rst ? rf : fl_s) | (ex ? ef : 6'h00);
      e_fp_error_out_n = !(base != 6'h00 || (lsv && op == fct_pkg::OP_LEG_SAVE_NW && fl_s != 6'h00));
      fl_s = base;
      if (tsw) ts_s = 1'b1;
      else if (run && op == fct_pkg::OP_CLR_TS) ts_s = 1'b0;
      else if (cw) ts_s = cd[3];
      if (cw) {ne_s, em_s} = {cd[5], cd[2]};
   endtask
   task automatic op1(fct_pkg::fct_op_t op, logic [31:0] a, logic o32);
      drv(1'b1, op, o32, a, 1'b0, 32'h0, 1'b0, 1'b0, 6'h00, 6'h2a);
   endtask
   task automatic crw(logic [31:0] d);
      drv(1'b0, fct_pkg::OP_OTHER, 1'b0, 32'h0, 1'b1, d, 1'b0, 1'b0, 6'h00, 6'h00);
   endtask
   // random offer with rare control, task switch and exception events
   task automatic rnd();
      logic [31:0] a;
      r = $random(seed);
      a = $random(seed);
      if (r[7]) a[3:0] = 4'h0;
      drv(r[4] | r[5], fct_pkg::fct_op_t'(r[3:0] % 4'ha), r[6], a, r[11:8] == 4'h0,
          $random(seed) & 32'hffff_fffb, r[15:12] == 4'h0, r[19:16] == 4'h0,
          r[25:20] | 6'h01, r[31:26]);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog
   initial begin
      #(4 * 12000);
      n_mismatch++;
      give_verdict();
   end
   // reset, corner cases, then random traffic with the kernel model
   initial begin
      {issue_valid_in, issue_op32_in, cr_wr_in, task_switch_in, fp_exc_in} = 5'h0;
      {issue_addr_in, cr_wdata_in, fp_exc_flags_in, restore_flags_in} = 76'h0;
      issue_op_in = fct_pkg::OP_OTHER;
      {em_s, ts_s, ne_s, fl_s} = 9'h0;
      repeat (6) @(negedge clk_in);
      chk("reset_err_n", fp_error_out_n, 1'b1);
      rstn_in = 1'b1;
      for (int i = 0; i < 8 && issue_ready_out !== 1'b1; i++) @(negedge clk_in);
      chk("ready", issue_ready_out, 1'b1);
      crw(32'h4);
      op1(fct_pkg::OP_FP, 32'h0, 1'b0);
      op1(fct_pkg::OP_PACKED_INT, 32'h0, 1'b0);
      crw(32'h2c);
      op1(fct_pkg::OP_PACKED_INT, 32'h0, 1'b0);
      crw(32'h28);
      drv(1'b0, fct_pkg::OP_OTHER, 1'b0, 32'h0, 1'b0, 32'h0, 1'b0, 1'b1, 6'h04, 6'h00);
      op1(fct_pkg::OP_FP, 32'h0, 1'b0);
      op1(fct_pkg::OP_CLR_TS, 32'h0, 1'b0);
      op1(fct_pkg::OP_FP, 32'h0, 1'b0);
      op1(fct_pkg::OP_WAIT, 32'h0, 1'b0);
      op1(fct_pkg::OP_LEG_SAVE_NW, 32'h0, 1'b1);
      drv(1'b1, fct_pkg::OP_CLR_TS, 1'b0, 32'h0, 1'b1, 32'h0, 1'b1, 1'b0, 6'h00, 6'h00);
      crw(32'h0);
      for (logic [3:0] k = 4'h4; k <= 4'h8; k++) begin
         for (int m = 0; m < 4; m++) op1(fct_pkg::fct_op_t'(k), {28'h0, 4'(m * 4)}, m[0]);
      end
      os_en = 1'b1;
      repeat (3000) rnd();
      repeat (6) crw(32'h0);
      give_verdict();
   end
endmodule
